// file: sec_consts.vh
// Constants for the serial word-memory command engine.
// Assumes inclusion by bare name from the engine files; definitions only.
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH

// Word layout and memory depth
`define SEC_WORD_W        16
`define SEC_ADDR_W        6
`define SEC_ERASED_WORD   16'hffff

// Two-bit opcodes following the start bit
`define SEC_OP_EXT        2'h0
`define SEC_OP_WRITE      2'h1
`define SEC_OP_READ       2'h2
`define SEC_OP_ERASE      2'h3

// Extended opcodes carried in the top two address bits
`define SEC_EXT_DISABLE   2'h0
`define SEC_EXT_FILL      2'h1
`define SEC_EXT_ERASE_ALL 2'h2
`define SEC_EXT_ENABLE    2'h3

// Program time in microseconds and the clock rate in MHz
`define SEC_PROGRAM_TIME_US 4000
`define SEC_CLK_MHZ         50

`endif

// file: sec_word_buf.v
// Two-entry word buffer with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sec_word_buf #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] slot_ff [0:1];
  reg             wr_ptr_ff;
  reg             rd_ptr_ff;
  reg [1:0]       count_ff;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data  = slot_ff[rd_ptr_ff];

  // Pointer and occupancy bookkeeping
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff  <= 1'b0;
      rd_ptr_ff  <= 1'b0;
      count_ff   <= 2'h0;
      slot_ff[0] <= {WIDTH{1'b0}};
      slot_ff[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        slot_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff          <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// file: sec_engine.v
// Command engine of a small three-wire serial memory of 16-bit words.
// Assumes select, serial clock, serial input and the supply flag come from another
// domain; all are synchronised to clk, and serial clock edges are found by sampling.
// Notes on behaviour
// - After last read address bit, drive output low until next serial clock rise.
// - Then shift out the addressed word, top bit first, on serial clock rises.
// - Holding select keeps streaming following words with the address incremented.
// - Sequential reading wraps from the top address back to zero.
// - Programming starts only when select falls after exactly the required clock count.
// - While programming, serial clock and input are ignored; host sends nothing.
// - Programming commands act only in write-enabled mode.
// - Every programming cycle completes within the program time.
// - Select high after programming start shows busy low, then ready high.
// - Input high at a clock rise during ready is a start bit; output floats.
// - Word erase sets the addressed word to all ones, no data.
// - Fill-all writes the following data word into every location.
// - Erase-all sets every word to all ones, ignoring address bits.
// - Enable and disable writes take effect when select falls.
// - Programming with a wrong clock count is cancelled, memory untouched.
// - Reset or low supply cancels programming and disables writes.
// - Bits are taken on serial clock rises with select high; select low idles.
// - Clocks with input low before the start bit are dummy clocks.
`timescale 1ns/1ps
`default_nettype none
`include "sec_consts.vh"

module sec_engine #(
  parameter ADDR_W       = `SEC_ADDR_W,
  parameter WORD_W       = `SEC_WORD_W,
  parameter PROG_CYCLES  = (`SEC_PROGRAM_TIME_US * `SEC_CLK_MHZ) / 2
) (
  // Clock and reset
  input  wire clk,
  input  wire reset_n,
  // Supply monitor, high while supply is too low
  input  wire low_supply,
  // Serial link
  input  wire select,
  input  wire serial_clock_in,
  input  wire serial_in,
  output reg  serial_out_ff,
  output reg  serial_out_oe_ff,
  // Status
  output reg  write_enabled_ff,
  output reg  programming_ff
);

  localparam CNT_W = 24;
  localparam [CNT_W-1:0] PROG_CNT = PROG_CYCLES;
  localparam DEPTH = 1 << ADDR_W;
  localparam [5:0] HDR_BITS = ADDR_W + 3;
  localparam [5:0] DATA_BITS = HDR_BITS + WORD_W;
  localparam [4:0] LAST_BIT = WORD_W - 1;

  // Link phases
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CMD   = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_PROG  = 3'h3;
  localparam [2:0] ST_HOLD  = 3'h4;

  // Program kinds
  localparam [2:0] PK_NONE  = 3'h0;
  localparam [2:0] PK_WORD  = 3'h1;
  localparam [2:0] PK_ERASE = 3'h2;
  localparam [2:0] PK_FILL  = 3'h3;
  localparam [2:0] PK_ERALL = 3'h4;

  // Two-stage synchronisers; only the second stage is read by logic.
  // The supply monitor is asynchronous too, so its flag passes the same stages.
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  reg       sclk_prev_ff;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff     <= 4'h0;
      sync2_ff     <= 4'h0;
      sclk_prev_ff <= 1'b0;
    end else begin
      sync1_ff     <= {low_supply, select, serial_clock_in, serial_in};
      sync2_ff     <= sync1_ff;
      sclk_prev_ff <= sync2_ff[1];
    end
  end
  wire low_s   = sync2_ff[3];
  wire cs_s    = sync2_ff[2];
  wire din_s   = sync2_ff[0];
  wire sk_rise = sync2_ff[1] & ~sclk_prev_ff;

  // Memory array in flip-flops, after an erase state of all ones
  reg [WORD_W-1:0] mem_ff [0:DEPTH-1];

  reg [2:0]        state_ff;
  reg [5:0]        bits_ff;
  reg [WORD_W+ADDR_W+1:0] shift_ff;
  reg [ADDR_W-1:0] addr_ff;
  reg [WORD_W-1:0] rd_word_ff;
  reg [4:0]        rd_bit_ff;
  reg              rd_lead_ff;
  reg [2:0]        kind_ff;
  reg [ADDR_W-1:0] prog_addr_ff;
  reg [WORD_W-1:0] prog_data_ff;
  reg [CNT_W-1:0]  prog_cnt_ff;
  reg              cs_prev_ff;

  // Words read from the array pass the two-entry buffer before shifting out
  wire              buf_in_ready;
  wire              buf_out_valid;
  wire [WORD_W-1:0] buf_out_data;
  reg               fetch_ff;
  reg               take_ff;
  sec_word_buf #(.WIDTH(WORD_W)) u_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fetch_ff),
    .in_ready  (buf_in_ready),
    .in_data   (mem_ff[addr_ff]),
    .out_valid (buf_out_valid),
    .out_ready (take_ff),
    .out_data  (buf_out_data)
  );

  // Decoded fields of the received header
  wire [1:0] opcode  = shift_ff[ADDR_W+1:ADDR_W];
  wire [1:0] ext_op  = shift_ff[ADDR_W-1:ADDR_W-2];
  wire       cs_fall = cs_prev_ff & ~cs_s;

  // Next address with wrap from top to zero
  function [ADDR_W-1:0] next_addr;
    input [ADDR_W-1:0] a;
    begin
      next_addr = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  integer i;

  // Main command sequencer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff         <= ST_IDLE;
      bits_ff          <= 6'h0;
      shift_ff         <= {(WORD_W+ADDR_W+2){1'b0}};
      addr_ff          <= {ADDR_W{1'b0}};
      rd_word_ff       <= {WORD_W{1'b0}};
      rd_bit_ff        <= 5'h0;
      rd_lead_ff       <= 1'b0;
      kind_ff          <= PK_NONE;
      prog_addr_ff     <= {ADDR_W{1'b0}};
      prog_data_ff     <= {WORD_W{1'b0}};
      prog_cnt_ff      <= {CNT_W{1'b0}};
      cs_prev_ff       <= 1'b0;
      write_enabled_ff <= 1'b0;
      programming_ff   <= 1'b0;
      serial_out_ff    <= 1'b0;
      serial_out_oe_ff <= 1'b0;
      fetch_ff         <= 1'b0;
      take_ff          <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= `SEC_ERASED_WORD;
      end
    end else begin
      cs_prev_ff <= cs_s;
      fetch_ff   <= 1'b0;
      // Outside a read, stale prefetched words drain so the next read starts clean
      take_ff    <= buf_out_valid & (state_ff != ST_READ);
      if (low_s) begin
        // Low supply cancels programming and drops the write mode
        write_enabled_ff <= 1'b0;
        programming_ff   <= 1'b0;
        serial_out_oe_ff <= 1'b0;
        state_ff         <= ST_IDLE;
      end else if (programming_ff) begin
        // Serial clock and input ignored until the cycle ends
        if (prog_cnt_ff == PROG_CNT) begin
          programming_ff <= 1'b0;
          case (kind_ff)
            PK_WORD:  mem_ff[prog_addr_ff] <= prog_data_ff;
            PK_ERASE: mem_ff[prog_addr_ff] <= `SEC_ERASED_WORD;
            PK_FILL: begin
              for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= prog_data_ff;
              end
            end
            PK_ERALL: begin
              for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= `SEC_ERASED_WORD;
              end
            end
            default: ;
          endcase
        end else begin
          prog_cnt_ff <= prog_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        // Busy level while selected, float otherwise
        serial_out_ff    <= 1'b0;
        serial_out_oe_ff <= cs_s;
        state_ff         <= ST_PROG;
      end else if (!cs_s) begin
        // Select low: idle, float, and launch a complete programming command
        serial_out_oe_ff <= 1'b0;
        // A finished cycle keeps its ready status for a later reselect
        state_ff         <= (state_ff == ST_PROG || state_ff == ST_HOLD) ? ST_PROG : ST_IDLE;
        rd_lead_ff       <= 1'b0;
        if (cs_fall && state_ff == ST_CMD) begin
          if (opcode == `SEC_OP_EXT && bits_ff == HDR_BITS) begin
            if (ext_op == `SEC_EXT_ENABLE) begin
              write_enabled_ff <= 1'b1;
            end else if (ext_op == `SEC_EXT_DISABLE) begin
              write_enabled_ff <= 1'b0;
            end
          end
          if (write_enabled_ff && kind_ff != PK_NONE) begin
            if (((kind_ff == PK_WORD || kind_ff == PK_FILL) && bits_ff == DATA_BITS) ||
                ((kind_ff == PK_ERASE || kind_ff == PK_ERALL) && bits_ff == HDR_BITS)) begin
              programming_ff <= 1'b1;
              prog_cnt_ff    <= {CNT_W{1'b0}};
              prog_data_ff   <= shift_ff[WORD_W-1:0];
            end
            // Any other count drops the command untouched
          end
        end
        bits_ff <= 6'h0;
      end else begin
        case (state_ff)
          ST_IDLE, ST_PROG, ST_HOLD: begin
            // Ready level shown after programming; dummy clocks skipped
            if (state_ff == ST_PROG || state_ff == ST_HOLD) begin
              serial_out_ff    <= 1'b1;
              serial_out_oe_ff <= 1'b1;
              state_ff         <= ST_HOLD;
            end
            if (sk_rise && din_s) begin
              state_ff         <= ST_CMD;
              serial_out_oe_ff <= 1'b0;
              bits_ff          <= 6'h1;
              shift_ff         <= {(WORD_W+ADDR_W+2){1'b0}};
              // Kind survives select falling, as the program cycle still needs it
              kind_ff          <= PK_NONE;
            end
          end
          ST_CMD: begin
            if (sk_rise) begin
              // Shift in opcode, address and data in arrival order
              shift_ff <= {shift_ff[WORD_W+ADDR_W:0], din_s};
              if (bits_ff != 6'h3f) begin
                bits_ff <= bits_ff + 6'h1;
              end
              if (bits_ff == HDR_BITS - 6'h1) begin
                // Classify the command on its last address bit
                case (shift_ff[ADDR_W:ADDR_W-1])
                  `SEC_OP_READ: begin
                    addr_ff          <= {shift_ff[ADDR_W-2:0], din_s};
                    fetch_ff         <= 1'b1;
                    state_ff         <= ST_READ;
                    serial_out_ff    <= 1'b0;
                    serial_out_oe_ff <= 1'b1;
                    rd_lead_ff       <= 1'b1;
                  end
                  `SEC_OP_WRITE: kind_ff <= PK_WORD;
                  `SEC_OP_ERASE: kind_ff <= PK_ERASE;
                  default: begin
                    if (shift_ff[ADDR_W-2:ADDR_W-3] == `SEC_EXT_FILL) begin
                      kind_ff <= PK_FILL;
                    end else if (shift_ff[ADDR_W-2:ADDR_W-3] == `SEC_EXT_ERASE_ALL) begin
                      kind_ff <= PK_ERALL;
                    end else begin
                      kind_ff <= PK_NONE;
                    end
                  end
                endcase
                prog_addr_ff <= {shift_ff[ADDR_W-2:0], din_s};
              end
            end
          end
          ST_READ: begin
            // Prefetch the next word while the current one shifts out
            if (sk_rise) begin
              if (rd_lead_ff || rd_bit_ff == 5'h0) begin
                rd_lead_ff       <= 1'b0;
                rd_word_ff       <= {buf_out_data[WORD_W-2:0], 1'b0};
                serial_out_ff    <= buf_out_data[WORD_W-1];
                take_ff          <= 1'b1;
                rd_bit_ff        <= LAST_BIT;
                addr_ff          <= next_addr(addr_ff);
                fetch_ff         <= buf_in_ready;
              end else begin
                serial_out_ff <= rd_word_ff[WORD_W-1];
                rd_word_ff    <= {rd_word_ff[WORD_W-2:0], 1'b0};
                rd_bit_ff     <= rd_bit_ff - 5'h1;
              end
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: sec_host_model.sv
// Host side of the serial link: drives select, serial clock and data.
// Assumes its tasks are called on a 20 ns grid, so edges stay clear of clk.
`timescale 1ns/1ps
`default_nettype none
module sec_host_model (
  // Link lines driven by the host
  output logic      select,
  output logic      serial_clock_in,
  output logic      serial_in,
  // Engine output and its enable
  input  wire logic serial_out_ff,
  input  wire logic serial_out_oe_ff
);
  // Data line as the host sees it; floats when the engine lets go
  wire line = serial_out_oe_ff ? serial_out_ff : 1'bz;

  // Idle link; the serial clock stands still between frames
  initial begin
    select = 1'h0;
    serial_clock_in = 1'h0;
    serial_in = 1'h0;
  end

  // 160 ns period: data set while low, line read just before the rise
  task automatic xfer(input logic si, output logic so);
    serial_in = si;
    #80;
    so = line;
    serial_clock_in = 1'h1;
    #80;
    serial_clock_in = 1'h0;
  endtask

  // Start bit, opcode, address, data, top bit first
  task automatic cmd(input logic [31:0] bits, input int n);
    logic so;
    select = 1'h1;
    for (int i = n - 1; i >= 0; i--) xfer(bits[i], so);
  endtask

  // Frame end; a deselected data line is not left at its old level
  task automatic drop;
    select = 1'h0;
    serial_in = ~serial_in;
    #160;
  endtask

  // Poll with data low and no command sent until ready
  task automatic poll(output logic busy, output logic ok);
    select = 1'h1;
    serial_in = 1'h0;
    #80;
    busy = (line === 1'h0);
    ok = 1'h0;
    for (int i = 0; i < 400 && !ok; i++) begin
      #20;
      ok = (line === 1'h1);
    end
  endtask
endmodule
`default_nettype wire

// file: sec_engine_chk.sv
// Concurrent checks on the ports of the serial memory command engine.
// Assumes it is bound to sec_engine with the same program length.
`timescale 1ns/1ps
`default_nettype none
module sec_engine_chk #(
  parameter PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Engine inputs
  input wire logic low_supply,
  input wire logic select,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  // Engine outputs
  input wire logic serial_out_ff,
  input wire logic serial_out_oe_ff,
  input wire logic write_enabled_ff,
  input wire logic programming_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] prog_cnt_ff;

  // Counter instead of a long delay range: the full-length cycle is too big
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) prog_cnt_ff <= 32'h0;
    else prog_cnt_ff <= programming_ff ? prog_cnt_ff + 32'h1 : 32'h0;
  end

  // Host starts a command while ready is shown
  sequence s_start;
    select && serial_out_oe_ff && serial_out_ff && serial_in && $rose(serial_clock_in);
  endsequence
  // Programming ends while the host keeps polling
  sequence s_done;
    $fell(programming_ff) ##0 select [*5];
  endsequence

  a_prog_bounded: assert property (prog_cnt_ff <= PROG_CYCLES + 2)
    else $error("programming ran too long");
  a_prog_on_drop: assert property ($rose(programming_ff) |-> !select && !$past(select))
    else $error("programming began with select high");
  a_prog_needs_wen: assert property ($rose(programming_ff) |-> $past(write_enabled_ff))
    else $error("programming while writes disabled");
  a_prog_quiet: assert property (programming_ff && $past(programming_ff) && !low_supply |-> $stable(write_enabled_ff))
    else $error("mode changed during programming");
  a_busy_low: assert property (programming_ff && $past(programming_ff) && serial_out_oe_ff |-> !serial_out_ff)
    else $error("ready shown while busy");
  a_busy_shown: assert property ((programming_ff && select) [*4] |-> serial_out_oe_ff)
    else $error("busy status not driven");
  a_ready_high: assert property (s_done |-> serial_out_oe_ff && serial_out_ff)
    else $error("ready not shown");
  a_start_floats: assert property (s_start |-> ##[1:5] !serial_out_oe_ff)
    else $error("output not floated on start bit");
  a_low_disables: assert property (low_supply |-> ##[1:4] !write_enabled_ff && !programming_ff)
    else $error("low supply not honoured");
  a_idle_float: assert property (!select [*4] |-> !serial_out_oe_ff)
    else $error("output driven while idle");
  a_mode_on_drop: assert property (!$stable(write_enabled_ff) |-> !select || low_supply)
    else $error("mode changed with select high");
endmodule

bind sec_engine sec_engine_chk #(.PROG_CYCLES(PROG_CYCLES)) sec_engine_chk_i (
  .clk              (clk),
  .reset_n          (reset_n),
  .low_supply       (low_supply),
  .select           (select),
  .serial_clock_in  (serial_clock_in),
  .serial_in        (serial_in),
  .serial_out_ff    (serial_out_ff),
  .serial_out_oe_ff (serial_out_oe_ff),
  .write_enabled_ff (write_enabled_ff),
  .programming_ff   (programming_ff)
);
`default_nettype wire

// file: tb_sec_engine.sv
// Self-checking bench for the serial memory command engine.
// Assumes the host model drives the link and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`include "sec_consts.vh"
module tb_sec_engine;
  logic        clk, reset_n, low_supply, d, busy, ok;
  logic [15:0] w;
  int          error_cnt, check_count;
  wire         sel, sck, sdi, sdo, oe, wen, prog;

  // 50 MHz clock
  initial clk = 1'h0;
  always #10 clk = ~clk;

  // Short program time keeps the run brief
  sec_engine #(.PROG_CYCLES(20)) sec_engine_i (.clk(clk), .reset_n(reset_n), .low_supply(low_supply),
    .select(sel), .serial_clock_in(sck), .serial_in(sdi), .serial_out_ff(sdo),
    .serial_out_oe_ff(oe), .write_enabled_ff(wen), .programming_ff(prog));
  sec_host_model sec_host_model_i (.select(sel), .serial_clock_in(sck), .serial_in(sdi),
    .serial_out_ff(sdo), .serial_out_oe_ff(oe));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Read command (n = 8 leaves out the start bit), then the low dummy bit
  task automatic rd_start(input logic [5:0] a, input int n);
    sec_host_model_i.cmd({1'h1, `SEC_OP_READ, a}, n);
    sec_host_model_i.xfer(1'h0, d);
    check(d, 1'h0);
  endtask

  task automatic rd_word(input logic [15:0] e);
    for (int i = 15; i >= 0; i--) sec_host_model_i.xfer(1'h0, w[i]);
    check(w, e);
  endtask

  // Accepted programming: nothing before select falls, then busy and ready
  task automatic prog_cmd(input logic [31:0] c, input int n);
    sec_host_model_i.cmd(c, n);
    check(prog, 1'h0);
    sec_host_model_i.drop;
    sec_host_model_i.poll(busy, ok);
    check(busy, 1'h1);
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: ready never shown", $time);
      test_done;
    end
  endtask

  // Refused programming never starts, so memory cannot change
  task automatic refused(input logic [31:0] c, input int n);
    sec_host_model_i.cmd(c, n);
    sec_host_model_i.drop;
    check(prog, 1'h0);
  endtask

  task automatic mode(input logic [1:0] x, input logic e);
    sec_host_model_i.cmd({1'h1, `SEC_OP_EXT, x, 4'h0}, 9);
    check(wen, !e);
    sec_host_model_i.drop;
    check(wen, e);
  endtask

  initial begin
    reset_n = 1'h0;
    low_supply = 1'h0;
    error_cnt = 0;
    check_count = 0;
    step(16);
    reset_n = 1'h1;
    step(4);
    check(wen, 1'h0);
    check(oe, 1'h0);
    refused({1'h1, `SEC_OP_WRITE, 6'h05, 16'h1234}, 25);
    rd_start(6'h05, 9);
    rd_word(`SEC_ERASED_WORD);
    sec_host_model_i.drop;
    mode(`SEC_EXT_ENABLE, 1'h1);
    prog_cmd({1'h1, `SEC_OP_WRITE, 6'h3f, 16'ha5c3}, 25);
    prog_cmd({1'h1, `SEC_OP_WRITE, 6'h00, 16'h0f0f}, 25);
    sec_host_model_i.xfer(1'h1, d);
    step(2);
    check(oe, 1'h0);
    rd_start(6'h3f, 8);
    rd_word(16'ha5c3);
    rd_word(16'h0f0f);
    sec_host_model_i.drop;
    refused({1'h1, `SEC_OP_ERASE, 6'h00, 1'h0}, 10);
    refused({1'h1, `SEC_OP_WRITE, 6'h00, 15'h0000}, 24);
    rd_start(6'h00, 9);
    rd_word(16'h0f0f);
    sec_host_model_i.drop;
    prog_cmd({1'h1, `SEC_OP_ERASE, 6'h00}, 9);
    rd_start(6'h00, 9);
    rd_word(`SEC_ERASED_WORD);
    sec_host_model_i.drop;
    prog_cmd({1'h1, `SEC_OP_EXT, `SEC_EXT_FILL, 4'h9, 16'h5a3c}, 25);
    rd_start(6'h3f, 9);
    rd_word(16'h5a3c);
    step(40);
    rd_word(16'h5a3c);
    sec_host_model_i.drop;
    prog_cmd({1'h1, `SEC_OP_EXT, `SEC_EXT_ERASE_ALL, 4'h5}, 9);
    rd_start(6'h11, 9);
    rd_word(`SEC_ERASED_WORD);
    sec_host_model_i.drop;
    // Poll by reselecting only after the cycle has ended: ready at once
    sec_host_model_i.cmd({1'h1, `SEC_OP_ERASE, 6'h11}, 9);
    sec_host_model_i.drop;
    step(40);
    sec_host_model_i.poll(busy, ok);
    check({busy, ok}, 2'h1);
    sec_host_model_i.drop;
    // Supply drop in mid-programming
    sec_host_model_i.cmd({1'h1, `SEC_OP_WRITE, 6'h11, 16'h1111}, 25);
    sec_host_model_i.drop;
    low_supply = 1'h1;
    step(5);
    check(prog, 1'h0);
    check(wen, 1'h0);
    low_supply = 1'h0;
    step(4);
    refused({1'h1, `SEC_OP_WRITE, 6'h22, 16'h2222}, 25);
    rd_start(6'h22, 9);
    rd_word(`SEC_ERASED_WORD);
    sec_host_model_i.drop;
    mode(`SEC_EXT_ENABLE, 1'h1);
    mode(`SEC_EXT_DISABLE, 1'h0);
    test_done;
  end
endmodule
`default_nettype wire
